// *** verilog/dcd_ctrl.sv ***
/*
 * converter clock delay-locked loop controller: registers, search and track
 * assumes a phase detector result arriving asynchronously on phase_meas
 */
`timescale 1ns/1ps
`include "dcd_cfg.svh"
module dcd_ctrl (
	input wire logic clk,
	input wire logic reset,
	input wire logic [11:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [4:0] phase_meas,
	output logic loop_power_down,
	output logic dig_clk_power_down,
	output logic [5:0] coarse_delay,
	output logic [7:0] fine_delay,
	output logic locked_flag,
	output logic lost_flag,
	output logic fail_flag
);
	logic pd_r, pd_nxt;
	logic [7:0] ctrl_r, ctrl_nxt;
	logic [3:0] guard_r, guard_nxt;
	logic [5:0] coarse_sp_r, coarse_sp_nxt;
	logic [7:0] fine_sp_r, fine_sp_nxt;
	logic [4:0] target_phase_r, target_phase_nxt;
	logic [4:0] bw_r, bw_nxt;
	logic rd_req_r, rd_req_nxt;
	logic rd_prev_r;
	logic [5:0] rb_coarse_r, rb_coarse_nxt;
	logic [7:0] rb_fine_r, rb_fine_nxt;
	logic [4:0] phase_readback_r, phase_readback_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic [4:0] meas_m_r, meas_s_r;
	dcd_pkg::dcd_state_t state_r, state_nxt;
	logic [5:0] coarse_r, coarse_nxt;
	logic [7:0] fine_r, fine_nxt;
	logic [9:0] wait_r, wait_nxt;
	logic dir_up_r, dir_up_nxt;
	logic flipped_r, flipped_nxt;
	logic locked_r, locked_nxt;
	logic lost_r, lost_nxt;
	logic fail_r, fail_nxt;
	logic [5:0] err, err_abs;
	logic in_win, tick, capture, wr_any, set_lost;
	logic [1:0] mode, dir;
	logic [7:0] step;

	assign wr_any = reg_wr;
	assign mode = ctrl_r[2:1];
	assign dir = ctrl_r[4:3];
	// signed distance to the target, sense set by slope
	assign err = ctrl_r[`DCD_CTRL_SLOPE] ? ({1'b0, meas_s_r} - {1'b0, target_phase_r})
		: ({1'b0, target_phase_r} - {1'b0, meas_s_r});
	assign err_abs = err[5] ? 6'(-err) : err;
	assign in_win = err_abs <= {2'h0, guard_r};
	assign tick = wait_r == 10'h000;
	assign capture = rd_req_r & ~rd_prev_r;
	assign step = 8'h01 << bw_r[1:0];

	// register file writes and reads
	always_comb
	begin
		pd_nxt = pd_r;
		ctrl_nxt = ctrl_r;
		guard_nxt = guard_r;
		coarse_sp_nxt = coarse_sp_r;
		fine_sp_nxt = fine_sp_r;
		target_phase_nxt = target_phase_r;
		bw_nxt = bw_r;
		rd_req_nxt = rd_req_r;
		rdata_nxt = rdata_r;
		if (wr_any)
		begin
			case (reg_addr)
				`DCD_OFF_PD: pd_nxt = reg_wdata[0];
				`DCD_OFF_CTRL: ctrl_nxt = reg_wdata;
				`DCD_OFF_GUARD: guard_nxt = reg_wdata[3:0];
				`DCD_OFF_COARSE: coarse_sp_nxt = reg_wdata[5:0];
				`DCD_OFF_FINE: fine_sp_nxt = reg_wdata;
				`DCD_OFF_PHASE: target_phase_nxt = reg_wdata[4:0];
				`DCD_OFF_BW: bw_nxt = reg_wdata[4:0];
				`DCD_OFF_READ: rd_req_nxt = reg_wdata[0];
				default: rd_req_nxt = rd_req_r;
			endcase
		end
		if (reg_rd)
		begin
			case (reg_addr)
				`DCD_OFF_PD: rdata_nxt = {7'h00, pd_r};
				`DCD_OFF_CTRL: rdata_nxt = ctrl_r;
				`DCD_OFF_STATUS: rdata_nxt = {5'h00, fail_r, lost_r, locked_r};
				`DCD_OFF_GUARD: rdata_nxt = {4'h0, guard_r};
				`DCD_OFF_COARSE: rdata_nxt = {2'h0, coarse_sp_r};
				`DCD_OFF_FINE: rdata_nxt = fine_sp_r;
				`DCD_OFF_PHASE: rdata_nxt = {3'h0, target_phase_r};
				`DCD_OFF_BW: rdata_nxt = {3'h0, bw_r};
				`DCD_OFF_READ: rdata_nxt = {7'h00, rd_req_r};
				`DCD_OFF_COARSE_RB: rdata_nxt = {2'h0, rb_coarse_r};
				`DCD_OFF_FINE_RB: rdata_nxt = rb_fine_r;
				`DCD_OFF_PHASE_RB: rdata_nxt = {3'h0, phase_readback_r};
				default: rdata_nxt = 8'h00;
			endcase
		end
	end

	// snapshot of delays and measured phase
	always_comb
	begin
		rb_coarse_nxt = rb_coarse_r;
		rb_fine_nxt = rb_fine_r;
		phase_readback_nxt = phase_readback_r;
		if (capture)
		begin
			rb_coarse_nxt = coarse_r;
			rb_fine_nxt = fine_r;
			phase_readback_nxt = meas_s_r;
		end
	end

	// loop controller
	always_comb
	begin
		state_nxt = state_r;
		coarse_nxt = coarse_r;
		fine_nxt = fine_r;
		wait_nxt = tick ? (`DCD_SETTLE_BASE << bw_r[4:2]) : 10'(wait_r - 10'h001);
		dir_up_nxt = dir_up_r;
		flipped_nxt = flipped_r;
		locked_nxt = locked_r;
		set_lost = 1'b0;
		fail_nxt = fail_r;
		if (pd_r)
		begin
			state_nxt = dcd_pkg::ST_OFF;
			locked_nxt = 1'b0;
			fail_nxt = 1'b0;
		end
		else if (!ctrl_r[`DCD_CTRL_ENABLE])
		begin
			state_nxt = dcd_pkg::ST_STATIC;
			coarse_nxt = coarse_sp_r;
			fine_nxt = fine_sp_r;
			locked_nxt = 1'b0;
			fail_nxt = 1'b0;
		end
		else
		begin
			case (state_r)
				dcd_pkg::ST_OFF, dcd_pkg::ST_STATIC:
				begin
					coarse_nxt = coarse_sp_r;
					fine_nxt = fine_sp_r;
					dir_up_nxt = dir != `DCD_DIR_DOWN;
					flipped_nxt = 1'b0;
					state_nxt = (mode == `DCD_MODE_TRACK) ? dcd_pkg::ST_TRACK : dcd_pkg::ST_SEARCH;
				end
				dcd_pkg::ST_SEARCH:
				begin
					if (tick && in_win)
					begin
						locked_nxt = 1'b1;
						state_nxt = (mode == `DCD_MODE_SEARCH) ? dcd_pkg::ST_HOLD : dcd_pkg::ST_TRACK;
					end
					else if (tick)
					begin
						if (dir_up_r ? coarse_r != `DCD_COARSE_MAX : coarse_r != 6'h00)
							coarse_nxt = dir_up_r ? 6'(coarse_r + 6'h01) : 6'(coarse_r - 6'h01);
						else if (dir == `DCD_DIR_BOTH && !flipped_r)
						begin
							coarse_nxt = coarse_sp_r;
							dir_up_nxt = 1'b0;
							flipped_nxt = 1'b1;
						end
						else
						begin
							fail_nxt = 1'b1;
							coarse_nxt = coarse_sp_r;
							dir_up_nxt = dir != `DCD_DIR_DOWN;
							flipped_nxt = 1'b0;
							if (!ctrl_r[`DCD_CTRL_SEARCH_ERR])
								state_nxt = dcd_pkg::ST_FAILED;
						end
					end
				end
				dcd_pkg::ST_TRACK:
				begin
					if (tick && in_win)
						locked_nxt = 1'b1;
					else if (tick)
					begin
						if (locked_r)
							set_lost = 1'b1;
						locked_nxt = 1'b0;
						if (err[5])
							fine_nxt = (fine_r >= step) ? 8'(fine_r - step) : 8'h00;
						else
							fine_nxt = (fine_r <= 8'(`DCD_FINE_MAX - step)) ? 8'(fine_r + step) : `DCD_FINE_MAX;
						if (locked_r && ctrl_r[`DCD_CTRL_TRACK_ERR] && mode != `DCD_MODE_TRACK)
						begin
							state_nxt = dcd_pkg::ST_SEARCH;
							coarse_nxt = coarse_sp_r;
							fine_nxt = fine_sp_r;
							dir_up_nxt = dir != `DCD_DIR_DOWN;
							flipped_nxt = 1'b0;
						end
					end
				end
				dcd_pkg::ST_HOLD, dcd_pkg::ST_FAILED: state_nxt = state_r;
				default: state_nxt = dcd_pkg::ST_OFF;
			endcase
		end
		// set wins over a software clear
		lost_nxt = set_lost | (lost_r & ~(reg_wr && reg_addr == `DCD_OFF_STATUS && !reg_wdata[`DCD_ST_LOST]));
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			pd_r <= `DCD_RST_PD;
			ctrl_r <= `DCD_RST_CTRL | {3'h0, `DCD_RST_DIR, 3'h0};
			guard_r <= 4'h0;
			coarse_sp_r <= `DCD_RST_COARSE;
			fine_sp_r <= `DCD_RST_FINE;
			target_phase_r <= `DCD_RST_PHASE;
			bw_r <= `DCD_RST_BW;
			rd_req_r <= 1'b0;
			rd_prev_r <= 1'b0;
			rb_coarse_r <= 6'h00;
			rb_fine_r <= 8'h00;
			phase_readback_r <= 5'h00;
			rdata_r <= 8'h00;
			meas_m_r <= 5'h00;
			meas_s_r <= 5'h00;
			state_r <= dcd_pkg::ST_OFF;
			coarse_r <= `DCD_RST_COARSE;
			fine_r <= `DCD_RST_FINE;
			wait_r <= `DCD_SETTLE_BASE;
			dir_up_r <= 1'b0;
			flipped_r <= 1'b0;
			locked_r <= 1'b0;
			lost_r <= 1'b0;
			fail_r <= 1'b0;
		end
		else
		begin
			pd_r <= pd_nxt;
			ctrl_r <= ctrl_nxt;
			guard_r <= guard_nxt;
			coarse_sp_r <= coarse_sp_nxt;
			fine_sp_r <= fine_sp_nxt;
			target_phase_r <= target_phase_nxt;
			bw_r <= bw_nxt;
			rd_req_r <= rd_req_nxt;
			rd_prev_r <= rd_req_r;
			rb_coarse_r <= rb_coarse_nxt;
			rb_fine_r <= rb_fine_nxt;
			phase_readback_r <= phase_readback_nxt;
			rdata_r <= rdata_nxt;
			meas_m_r <= phase_meas;
			meas_s_r <= meas_m_r;
			state_r <= state_nxt;
			coarse_r <= coarse_nxt;
			fine_r <= fine_nxt;
			wait_r <= wait_nxt;
			dir_up_r <= dir_up_nxt;
			flipped_r <= flipped_nxt;
			locked_r <= locked_nxt;
			lost_r <= lost_nxt;
			fail_r <= fail_nxt;
		end
	end

	assign reg_rdata = rdata_r;
	assign loop_power_down = pd_r;
	assign dig_clk_power_down = pd_r;
	assign coarse_delay = coarse_r;
	assign fine_delay = fine_r;
	assign locked_flag = locked_r;
	assign lost_flag = lost_r;
	assign fail_flag = fail_r;

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence snap_s;
		rd_req_r && !rd_prev_r;
	endsequence

	pd_off_a: assert property (pd_r |=> state_r == dcd_pkg::ST_OFF && !locked_r)
		else $error("loop ran while powered down");
	static_src_a: assert property (!pd_r && !ctrl_r[0] |=> coarse_r == $past(coarse_sp_r)
		&& fine_r == $past(fine_sp_r)) else $error("static setpoints not applied");
	track_only_a: assert property (state_r == dcd_pkg::ST_STATIC && !pd_r && ctrl_r[0] && ctrl_r[2:1] == 2'h1
		|=> state_r == dcd_pkg::ST_TRACK) else $error("track only mode not entered");
	dir_down_a: assert property (state_r == dcd_pkg::ST_SEARCH && ctrl_r[4:3] == 2'h0
		&& coarse_nxt != coarse_r && state_nxt == dcd_pkg::ST_SEARCH && !fail_nxt
		|-> coarse_nxt == 6'(coarse_r - 6'h01)) else $error("downward search stepped up");
	fail_src_a: assert property ($rose(fail_r) |-> $past(state_r) == dcd_pkg::ST_SEARCH)
		else $error("fail outside search");
	lost_src_a: assert property ($rose(lost_r) |-> $past(locked_r) && !locked_r)
		else $error("lost without prior lock");
	lock_src_a: assert property ($rose(locked_r) |-> $past(in_win) && $past(tick))
		else $error("lock outside window");
	step_pace_a: assert property (state_r == dcd_pkg::ST_SEARCH && !tick && ctrl_r[0] && !pd_r
		|=> $stable(coarse_r)) else $error("coarse stepped before settle");
	capture_a: assert property (snap_s |=> rb_coarse_r == $past(coarse_r)
		&& rb_fine_r == $past(fine_r) && phase_readback_r == $past(meas_s_r)) else $error("snapshot not captured");
	rb_hold_a: assert property (!(rd_req_r && !rd_prev_r) |=> $stable(rb_coarse_r) && $stable(rb_fine_r)
		&& $stable(phase_readback_r)) else $error("readback changed without request");
endmodule // dcd_ctrl

// *** verilog/dcd_cfg.svh ***
/*
 * register offsets, field positions, reset values and timing counts
 * of the converter clock loop controller; included by its bare name
 */
`ifndef DCD_CFG_SVH
`define DCD_CFG_SVH
`define DCD_ADDR_W 12
`define DCD_OFF_PD 12'h090
`define DCD_OFF_CTRL 12'h091
`define DCD_OFF_STATUS 12'h092
`define DCD_OFF_GUARD 12'h093
`define DCD_OFF_COARSE 12'h094
`define DCD_OFF_FINE 12'h095
`define DCD_OFF_PHASE 12'h096
`define DCD_OFF_BW 12'h097
`define DCD_OFF_READ 12'h098
`define DCD_OFF_COARSE_RB 12'h099
`define DCD_OFF_FINE_RB 12'h09a
`define DCD_OFF_PHASE_RB 12'h09b
`define DCD_CTRL_TRACK_ERR 7
`define DCD_CTRL_SEARCH_ERR 6
`define DCD_CTRL_SLOPE 5
`define DCD_CTRL_ENABLE 0
`define DCD_ST_FAIL 2
`define DCD_ST_LOST 1
`define DCD_ST_LOCKED 0
`define DCD_RST_PD 1'h1
`define DCD_RST_CTRL 8'he0
`define DCD_RST_DIR 2'h2
`define DCD_RST_COARSE 6'h00
`define DCD_RST_FINE 8'h80
`define DCD_RST_PHASE 5'h08
`define DCD_RST_BW 5'h00
`define DCD_MODE_SRCH_TRK 2'h0
`define DCD_MODE_TRACK 2'h1
`define DCD_MODE_SEARCH 2'h2
`define DCD_DIR_DOWN 2'h0
`define DCD_DIR_UP 2'h1
`define DCD_DIR_BOTH 2'h2
`define DCD_COARSE_MAX 6'h3f
`define DCD_FINE_MAX 8'hff
`define DCD_SETTLE_BASE 10'h004
`endif

// *** verilog/dcd_pkg.sv ***
/*
 * types of the converter clock loop controller
 * assumes dcd_cfg.svh supplies the numeric constants
 */
package dcd_pkg;
	typedef enum logic [2:0] {ST_OFF, ST_STATIC, ST_SEARCH, ST_TRACK, ST_HOLD, ST_FAILED} dcd_state_t;
endpackage

// *** verif/tb_dcd_ctrl.sv ***
/*
 * self-checking bench of the clock loop controller: registers, snapshot, lock flags
 * assumes dcd_ctrl alone, reached through its register strobes
 */
`timescale 1ns/1ps
`include "dcd_cfg.svh"
module tb_dcd_ctrl;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [11:0] reg_addr = 12'h000;
	logic reg_wr = 1'b0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic [4:0] phase_meas = 5'h00;
	logic loop_power_down, dig_clk_power_down, locked_flag, lost_flag, fail_flag;
	logic [5:0] coarse_delay;
	logic [7:0] fine_delay;
	logic [2:0] fl;
	logic [31:0] seed = 32'h52cc18f8;
	int fails = 0;
	int n_compared = 0;
	int i, k, n;
	logic [7:0] rd_v, c_v, f_v;
	logic [4:0] p_v;
	logic [7:0] rst_tab [12] = '{8'h01, 8'hf0, 8'h00, 8'h00, 8'h00, 8'h80, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

	assign fl = {fail_flag, lost_flag, locked_flag};

	always #20 clk = ~clk;

	dcd_ctrl u_dcd_ctrl (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .phase_meas(phase_meas),
		.loop_power_down(loop_power_down), .dig_clk_power_down(dig_clk_power_down),
		.coarse_delay(coarse_delay), .fine_delay(fine_delay), .locked_flag(locked_flag),
		.lost_flag(lost_flag), .fail_flag(fail_flag));

	function automatic logic [7:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed[7:0];
	endfunction

	// fine delay after one tracking step upward, saturating
	function automatic logic [7:0] exp_fine(input logic [7:0] f, input logic [1:0] w);
		logic [8:0] s;
		s = {1'b0, f} + (9'h001 << w);
		return s[8] ? 8'hff : s[7:0];
	endfunction

	// cycles between two loop evaluations for a filter setting
	function automatic logic [7:0] exp_period(input logic [2:0] fb);
		return 8'((`DCD_SETTLE_BASE << fb) + 10'h001);
	endfunction

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string w);
		n_compared++;
		if (got !== exp)
		begin
			fails++;
			$display("[ERR] %0t %s got %h exp %h", $time, w, got, exp);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask

	task automatic rchk(input logic [11:0] a, input logic [7:0] e, input string w);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		@(negedge clk);
		chk(reg_rdata, e, w);
	endtask

	// bounded wait for one status flag
	task automatic wait_fl(input int b, input int lim, output logic [7:0] s);
		s = 8'h00;
		repeat (lim)
		begin
			@(negedge clk);
			if (fl[b] === 1'b1)
			begin
				s = 8'h01;
				break;
			end
		end
	endtask

	// bounded wait for the fine delay to move, cycles counted
	task automatic wait_fine(input logic [7:0] from, output int cyc);
		cyc = 0;
		repeat (100)
		begin
			@(negedge clk);
			cyc++;
			if (fine_delay !== from)
				break;
		end
	endtask

	task summarize;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial
	begin
		#(40 * 30000);
		fails++;
		$display("[ERR] %0t watchdog expired", $time);
		summarize;
	end

	initial
	begin
		repeat (10) @(negedge clk);
		reset = 1'b0;
		for (i = 0; i < 12; i++)
			rchk(12'h090 + 12'(i), rst_tab[i], "reset value");
		chk({6'h00, loop_power_down, dig_clk_power_down}, 8'h03, "pd pins");
		chk({2'b00, coarse_delay}, 8'h00, "coarse pin");
		chk(fine_delay, 8'h80, "fine pin");
		chk({5'h00, fl}, 8'h00, "flags");
		// enable while powered down must not lock
		phase_meas = 5'h08;
		wr(12'h091, 8'hf1);
		wait_fl(0, 60, rd_v);
		chk(rd_v, 8'h00, "lock in power down");
		wr(12'h091, 8'hf0);
		wr(12'h090, 8'h00);
		chk({6'h00, loop_power_down, dig_clk_power_down}, 8'h00, "pd pins");
		for (k = 0; k < 8; k++)
		begin
			c_v = (k == 0) ? 8'hff : (k == 1) ? 8'h00 : rnd();
			f_v = (k == 0) ? 8'hff : (k == 1) ? 8'h00 : rnd();
			p_v = 5'(rnd());
			phase_meas = p_v;
			wr(12'h094, c_v);
			wr(12'h095, f_v);
			@(negedge clk);
			chk({2'b00, coarse_delay}, c_v & 8'h3f, "coarse pin");
			chk(fine_delay, f_v, "fine pin");
			rchk(12'h094, c_v & 8'h3f, "coarse reg");
			rd_v = rnd();
			wr(12'h097, rd_v);
			rchk(12'h097, rd_v & 8'h1f, "bandwidth");
			wr(12'h093, rd_v);
			rchk(12'h093, rd_v & 8'h0f, "guard");
			wr(12'h098, 8'h01);
			rchk(12'h099, c_v & 8'h3f, "coarse rb");
			rchk(12'h09a, f_v, "fine rb");
			rchk(12'h09b, {3'h0, p_v}, "phase rb");
			// no rising request: snapshot must stand
			wr(12'h094, ~c_v);
			wr(12'h095, ~f_v);
			phase_meas = ~p_v;
			wr(12'h098, 8'h01);
			wr(12'h099, 8'h2a);
			wr(12'h092, 8'hfd);
			rchk(12'h099, c_v & 8'h3f, "coarse rb held");
			rchk(12'h09a, f_v, "fine rb held");
			rchk(12'h09b, {3'h0, p_v}, "phase rb held");
			rchk(12'h092, 8'h00, "status ro");
			wr(12'h098, 8'h00);
		end
		rchk(12'h0a0, 8'h00, "unmapped");
		// lock in each mode with phase on target
		for (k = 0; k < 3; k++)
		begin
			wr(12'h091, 8'hf0);
			wr(12'h094, 8'h20);
			wr(12'h093, 8'h01);
			wr(12'h097, 8'h00);
			p_v = 5'(rnd() % 8'd17);
			wr(12'h096, {3'h0, p_v});
			phase_meas = p_v;
			wr(12'h091, 8'hf1 | 8'(k << 1));
			wait_fl(0, 200, rd_v);
			chk(rd_v, 8'h01, "lock");
			rchk(12'h092, 8'h01, "status locked");
			if (k != 2)
			begin
				phase_meas = p_v ^ 5'h10;
				wait_fl(1, 200, rd_v);
				chk(rd_v, 8'h01, "lost");
				wr(12'h092, 8'h00);
				chk({7'h00, lost_flag}, 8'h00, "lost cleared");
			end
		end
		// search only, stop on error, each direction
		for (k = 0; k < 3; k++)
		begin
			wr(12'h091, 8'hb0);
			wr(12'h094, 8'h20);
			wr(12'h093, 8'h00);
			wr(12'h096, 8'h08);
			phase_meas = 5'h18;
			wr(12'h091, 8'ha5 | 8'(k << 3));
			n = 0;
			repeat (1000)
			begin
				@(negedge clk);
				if ((k == 0 && coarse_delay > 6'h20) || (k == 1 && coarse_delay < 6'h20))
					n++;
				if (fail_flag === 1'b1)
					break;
			end
			chk(8'(n), 8'h00, "search direction");
			chk({7'h00, fail_flag}, 8'h01, "fail");
			c_v = {2'b00, coarse_delay};
			repeat (40) @(negedge clk);
			chk({2'b00, coarse_delay}, c_v, "stopped");
			rchk(12'h092, 8'h04, "status fail");
		end
		// track only, off target: fine walks up by the weight once per settle period
		for (k = 0; k < 4; k++)
		begin
			rd_v = (k == 0) ? 8'h0f : rnd() & 8'h0f;
			wr(12'h091, 8'hf0);
			wr(12'h095, 8'h80);
			wr(12'h093, 8'h00);
			wr(12'h097, rd_v);
			wr(12'h096, 8'h08);
			phase_meas = 5'h18;
			wr(12'h091, 8'hf3);
			wait_fine(8'h80, n);
			chk(fine_delay, exp_fine(8'h80, rd_v[1:0]), "track step");
			c_v = fine_delay;
			wait_fine(c_v, n);
			chk(8'(n), exp_period(rd_v[4:2]), "settle period");
			chk(fine_delay, exp_fine(c_v, rd_v[1:0]), "track step");
		end
		summarize;
	end
endmodule // tb_dcd_ctrl
